// >>> alcr_consts.svh
// Named offsets, field positions, widths and reset values of the lane control registers
`ifndef ALCR_CONSTS_SVH
`define ALCR_CONSTS_SVH

// ***********************************************
// Register indices (byte address is index times four)
// ***********************************************
`define ALCR_IDX_PATTERN      10'h017
`define ALCR_IDX_POWER        10'h018
`define ALCR_IDX_GAIN_OFFSET  10'h019
`define ALCR_IDX_OFFSET_COPY  10'h01a
`define ALCR_IDX_ENABLES      10'h01f
`define ALCR_IDX_CUSTOM       10'h020
`define ALCR_ADDR_W           12
`define ALCR_IDX_LSB          2
`define ALCR_BYTE_OFS         2'h0

// ***********************************************
// Field positions
// ***********************************************
`define ALCR_PAT3_HI          7
`define ALCR_PAT3_LO          5
`define ALCR_PAT4_HI          4
`define ALCR_PAT4_LO          2
`define ALCR_DIG_HI           15
`define ALCR_DIG_LO           12
`define ALCR_LSLP_HI          11
`define ALCR_LSLP_LO          8
`define ALCR_ANA_HI           7
`define ALCR_ANA_LO           4
`define ALCR_FLIP_HI          3
`define ALCR_FLIP_LO          0
`define ALCR_GAIN_HI          15
`define ALCR_GAIN_LO          11
`define ALCR_BIAS_HI          9
`define ALCR_BIAS_LO          0
`define ALCR_EN_PATTERN       0
`define ALCR_EN_GAIN          1
`define ALCR_EN_BIAS          2
`define ALCR_EN_MISMATCH      3

// ***********************************************
// Write masks and reset values
// ***********************************************
`define ALCR_MASK_PATTERN     16'h00fc
`define ALCR_MASK_POWER       16'hffff
`define ALCR_MASK_GAIN_OFFSET 16'hfbff
`define ALCR_MASK_OFFSET_COPY 16'h03ff
`define ALCR_MASK_ENABLES     16'h0007
`define ALCR_MASK_CUSTOM      16'h3fff
`define ALCR_RESET_VAL        16'h0000
`define ALCR_REG_W            16

// ***********************************************
// Datapath
// ***********************************************
`define ALCR_SAMPLE_W         14
`define ALCR_GAIN_W           5
`define ALCR_BIAS_W           10
`define ALCR_FACTOR_W         12
`define ALCR_FACTOR_FRAC      10
`define ALCR_FACTOR_UNITY     12'h400
`define ALCR_SAT_MAX          14'h1fff
`define ALCR_SAT_MIN          14'h2000
`define ALCR_ALT_WORD         14'h1555
`define ALCR_SYNC_WORD        14'h3f80
`define ALCR_LINES            4

`endif

// >>> alcr_pkg.sv
// Types shared by the lane control register files
package alcr_pkg;

   // Test pattern codes of one serial output line
   typedef enum logic [2:0] {
      ALCR_PAT_NORMAL = 3'b000,
      ALCR_PAT_SYNC   = 3'b001,
      ALCR_PAT_ALT    = 3'b010,
      ALCR_PAT_CUSTOM = 3'b011,
      ALCR_PAT_ONES   = 3'b100,
      ALCR_PAT_TOGGLE = 3'b101,
      ALCR_PAT_ZEROS  = 3'b110,
      ALCR_PAT_RAMP   = 3'b111
   } alcr_pattern_t;

endpackage

// >>> alcr_lane_fmt.sv
// Output word formatter of one serial line: pattern, inversion and sleep
`include "alcr_consts.svh"

module alcr_lane_fmt
   import alcr_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       srst,
   input  wire logic                       sampleValid,
   input  wire logic [`ALCR_SAMPLE_W-1:0]  sampleIn,
   input  alcr_pattern_t                   patternCode,
   input  wire logic [`ALCR_SAMPLE_W-1:0]  customWord,
   input  wire logic                       lineSleep,
   input  wire logic                       lineFlip,
   output logic      [`ALCR_SAMPLE_W-1:0]  sampleOut,
   output logic                            sampleOutValid
);

   logic [`ALCR_SAMPLE_W-1:0] ramp_r;
   logic [`ALCR_SAMPLE_W-1:0] ramp_nxt;
   logic                      togglePhase_r;
   logic [`ALCR_SAMPLE_W-1:0] patWord;
   logic [`ALCR_SAMPLE_W-1:0] flipWord;
   logic [`ALCR_SAMPLE_W-1:0] outWord;

   // ***********************************************
   // Pattern word selection
   // ***********************************************
   // Ramp and toggle advance once per accepted sample
   assign ramp_nxt = ramp_r + {{(`ALCR_SAMPLE_W-1){1'b0}}, 1'b1};

   always_comb
   begin
      case (patternCode)
         ALCR_PAT_NORMAL: patWord = sampleIn;
         ALCR_PAT_SYNC:   patWord = `ALCR_SYNC_WORD;
         ALCR_PAT_ALT:    patWord = `ALCR_ALT_WORD;
         ALCR_PAT_CUSTOM: patWord = customWord;
         ALCR_PAT_ONES:   patWord = {`ALCR_SAMPLE_W{1'b1}};
         ALCR_PAT_TOGGLE: patWord = togglePhase_r ? ~`ALCR_ALT_WORD : `ALCR_ALT_WORD;
         ALCR_PAT_ZEROS:  patWord = {`ALCR_SAMPLE_W{1'b0}};
         default:         patWord = ramp_r;
      endcase
   end

   // Inversion of the transmitted word
   assign flipWord = lineFlip ? ~patWord : patWord;
   // A sleeping line sends nothing
   assign outWord  = lineSleep ? {`ALCR_SAMPLE_W{1'b0}} : flipWord;

   // ***********************************************
   // Registers
   // ***********************************************
   // Pattern sequencers
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ramp_r        <= {`ALCR_SAMPLE_W{1'b0}};
         togglePhase_r <= 1'b0;
      end
      else if (sampleValid)
      begin
         ramp_r        <= ramp_nxt;
         togglePhase_r <= ~togglePhase_r;
      end
   end

   // Output word and its strobe
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sampleOut      <= {`ALCR_SAMPLE_W{1'b0}};
         sampleOutValid <= 1'b0;
      end
      else
      begin
         sampleOut      <= sampleValid ? outWord : sampleOut;
         sampleOutValid <= sampleValid & ~lineSleep;
      end
   end

endmodule

// >>> alcr_lane_control_regs.sv
// Lane control register bank with APB slave, line formatters and channel-5 gain/offset path
// How it works
// - With per-line pattern selection on, bits 7-5 pick the pattern of line 3 and bits 4-2 that of line 4.
// - Pattern codes are 000 normal, 001 sync, 010 alternating, 011 custom, 100 ones, 101 toggle, 110 zeros, 111 ramp.
// - Bits 15-12 put the digital block of channels 4, 3, 2, 1 to sleep, clear after reset.
// - Bits 11-8 shut down serial lines 4, 3, 2, 1, clear after reset.
// - Bits 7-4 put the analog block of channels 4, 3, 2, 1 to sleep, clear after reset.
// - Bits 3-0 invert the data sent on lines 4, 3, 2, 1.
// - With gain enabled, the unsigned field at bits 15-11 gives channel 5 a gain of N times 0.2 dB.
// - With offset enabled, the two's-complement field at bits 9-0 is added to channel 5 data.
//
// Register access over APB was chosen for this implementation.
`include "alcr_consts.svh"

module alcr_lane_control_regs
   import alcr_pkg::*;
(
   input  wire logic                                     sys_clk,
   input  wire logic                                     srst,
   input  wire logic                                     psel,
   input  wire logic                                     penable,
   input  wire logic                                     pwrite,
   input  wire logic [`ALCR_ADDR_W-1:0]                  paddr,
   input  wire logic [31:0]                              pwdata,
   output logic      [31:0]                              prdata,
   output logic                                          pready,
   output logic                                          pslverr,
   input  wire logic                                     laneValid,
   input  wire logic [`ALCR_LINES-1:0][`ALCR_SAMPLE_W-1:0] laneDataIn,
   output logic      [`ALCR_LINES-1:0][`ALCR_SAMPLE_W-1:0] laneDataOut,
   output logic      [`ALCR_LINES-1:0]                   laneDataOutValid,
   input  wire logic                                     chan5Valid,
   input  wire logic [`ALCR_SAMPLE_W-1:0]                chan5DataIn,
   output logic      [`ALCR_SAMPLE_W-1:0]                chan5DataOut,
   output logic                                          chan5DataOutValid,
   output logic      [3:0]                               chanDigitalSleep,
   output logic      [3:0]                               chanAnalogSleep,
   output logic      [3:0]                               lineOutputSleep,
   output logic      [3:0]                               lineDataFlip,
   output logic      [2:0]                               line3PatternCode,
   output logic      [2:0]                               line4PatternCode,
   output logic      [`ALCR_GAIN_W-1:0]                  chan5GainSteps,
   output logic      [`ALCR_BIAS_W-1:0]                  chan5SignedBias
);

   // ***********************************************
   // Register storage
   // ***********************************************
   logic [`ALCR_REG_W-1:0] patternSel_r;
   logic [`ALCR_REG_W-1:0] powerInvert_r;
   logic [`ALCR_REG_W-1:0] gainOffset_r;
   logic [`ALCR_REG_W-1:0] offsetCopy_r;
   logic [`ALCR_REG_W-1:0] enables_r;
   logic [`ALCR_REG_W-1:0] custom_r;
   logic [31:0]            prdata_nxt;

   // ***********************************************
   // APB decode
   // ***********************************************
   logic [9:0] regIdx;
   logic       alignedAddr;
   logic       hitPattern;
   logic       hitPower;
   logic       hitGainOffset;
   logic       hitOffsetCopy;
   logic       hitEnables;
   logic       hitCustom;
   logic       hitAny;
   logic       setupPhase;
   logic       accessPhase;
   logic       wrStrobe;
   logic [`ALCR_REG_W-1:0] wrWord;

   // Word index and aligned decode of the byte address
   assign regIdx        = paddr[`ALCR_ADDR_W-1:`ALCR_IDX_LSB];
   assign alignedAddr   = (paddr[`ALCR_IDX_LSB-1:0] == `ALCR_BYTE_OFS);
   assign hitPattern    = alignedAddr && (regIdx == `ALCR_IDX_PATTERN);
   assign hitPower      = alignedAddr && (regIdx == `ALCR_IDX_POWER);
   assign hitGainOffset = alignedAddr && (regIdx == `ALCR_IDX_GAIN_OFFSET);
   assign hitOffsetCopy = alignedAddr && (regIdx == `ALCR_IDX_OFFSET_COPY);
   assign hitEnables    = alignedAddr && (regIdx == `ALCR_IDX_ENABLES);
   assign hitCustom     = alignedAddr && (regIdx == `ALCR_IDX_CUSTOM);
   assign hitAny        = hitPattern | hitPower | hitGainOffset | hitOffsetCopy
                        | hitEnables | hitCustom;

   // Zero-wait slave: every access phase completes at once
   assign setupPhase  = psel & ~penable;
   assign accessPhase = psel & penable;
   assign pready      = 1'b1;
   assign pslverr     = accessPhase & ~hitAny;
   assign wrStrobe    = accessPhase & pwrite & hitAny;
   assign wrWord      = pwdata[`ALCR_REG_W-1:0];

   // ***********************************************
   // Status and effective controls
   // ***********************************************
   logic biasMismatch;
   logic patEnable;
   logic gainEnable;
   logic biasEnable;
   logic [`ALCR_REG_W-1:0] enablesView;

   assign patEnable  = enables_r[`ALCR_EN_PATTERN];
   assign gainEnable = enables_r[`ALCR_EN_GAIN];
   assign biasEnable = enables_r[`ALCR_EN_BIAS];

   // Flags a difference between the two copies of the channel-5 offset
   assign biasMismatch = gainOffset_r[`ALCR_BIAS_HI:`ALCR_BIAS_LO]
                      != offsetCopy_r[`ALCR_BIAS_HI:`ALCR_BIAS_LO];

   // Enables register with the mismatch flag shown as a read-only bit
   always_comb
   begin
      enablesView = enables_r;
      enablesView[`ALCR_EN_MISMATCH] = biasMismatch;
   end

   // Read data chosen from the decoded register; unmapped reads give zero
   assign prdata_nxt = hitPattern    ? {16'h0000, patternSel_r}  :
                       hitPower      ? {16'h0000, powerInvert_r} :
                       hitGainOffset ? {16'h0000, gainOffset_r}  :
                       hitOffsetCopy ? {16'h0000, offsetCopy_r}  :
                       hitEnables    ? {16'h0000, enablesView}   :
                       hitCustom     ? {16'h0000, custom_r}      :
                                       32'h0000_0000;

   // ***********************************************
   // Register writes
   // ***********************************************
   // Only documented field bits are stored; reserved bits read as zero
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         patternSel_r  <= `ALCR_RESET_VAL;
         powerInvert_r <= `ALCR_RESET_VAL;
         gainOffset_r  <= `ALCR_RESET_VAL;
         offsetCopy_r  <= `ALCR_RESET_VAL;
         enables_r     <= `ALCR_RESET_VAL;
         custom_r      <= `ALCR_RESET_VAL;
      end
      else if (wrStrobe)
      begin
         if (hitPattern)
            patternSel_r  <= wrWord & `ALCR_MASK_PATTERN;
         if (hitPower)
            powerInvert_r <= wrWord & `ALCR_MASK_POWER;
         if (hitGainOffset)
            gainOffset_r  <= wrWord & `ALCR_MASK_GAIN_OFFSET;
         if (hitOffsetCopy)
            offsetCopy_r  <= wrWord & `ALCR_MASK_OFFSET_COPY;
         if (hitEnables)
            enables_r     <= wrWord & `ALCR_MASK_ENABLES;
         if (hitCustom)
            custom_r      <= wrWord & `ALCR_MASK_CUSTOM;
      end
   end

   // Read data captured in the setup phase, held through the access phase
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         prdata <= 32'h0000_0000;
      else if (setupPhase & ~pwrite)
         prdata <= prdata_nxt;
   end

   // ***********************************************
   // Control outputs
   // ***********************************************
   assign chanDigitalSleep = powerInvert_r[`ALCR_DIG_HI:`ALCR_DIG_LO];
   assign lineOutputSleep  = powerInvert_r[`ALCR_LSLP_HI:`ALCR_LSLP_LO];
   assign chanAnalogSleep  = powerInvert_r[`ALCR_ANA_HI:`ALCR_ANA_LO];
   assign lineDataFlip     = powerInvert_r[`ALCR_FLIP_HI:`ALCR_FLIP_LO];

   // Pattern codes take effect only with per-line selection on
   assign line3PatternCode = patEnable ? patternSel_r[`ALCR_PAT3_HI:`ALCR_PAT3_LO]
                                       : ALCR_PAT_NORMAL;
   assign line4PatternCode = patEnable ? patternSel_r[`ALCR_PAT4_HI:`ALCR_PAT4_LO]
                                       : ALCR_PAT_NORMAL;

   assign chan5GainSteps  = gainEnable ? gainOffset_r[`ALCR_GAIN_HI:`ALCR_GAIN_LO]
                                       : {`ALCR_GAIN_W{1'b0}};
   assign chan5SignedBias = biasEnable ? gainOffset_r[`ALCR_BIAS_HI:`ALCR_BIAS_LO]
                                       : {`ALCR_BIAS_W{1'b0}};

   // ***********************************************
   // Serial line formatters
   // ***********************************************
   alcr_pattern_t linePattern [`ALCR_LINES];

   // Lines 1 and 2 take their pattern elsewhere and pass data here
   assign linePattern[0] = ALCR_PAT_NORMAL;
   assign linePattern[1] = ALCR_PAT_NORMAL;
   assign linePattern[2] = alcr_pattern_t'(line3PatternCode);
   assign linePattern[3] = alcr_pattern_t'(line4PatternCode);

   for (genvar ln = 0; ln < `ALCR_LINES; ln++)
   begin : g_line
      alcr_lane_fmt u_fmt (
         .sys_clk        (sys_clk),
         .srst           (srst),
         .sampleValid    (laneValid),
         .sampleIn       (laneDataIn[ln]),
         .patternCode    (linePattern[ln]),
         .customWord     (custom_r[`ALCR_SAMPLE_W-1:0]),
         .lineSleep      (lineOutputSleep[ln]),
         .lineFlip       (lineDataFlip[ln]),
         .sampleOut      (laneDataOut[ln]),
         .sampleOutValid (laneDataOutValid[ln])
      );
   end

   // ***********************************************
   // Channel-5 gain and offset path
   // ***********************************************
   localparam int SUM_W  = `ALCR_SAMPLE_W + 1;
   localparam int PROD_W = SUM_W + `ALCR_FACTOR_W + 1;

   logic [`ALCR_FACTOR_W-1:0] gainFactor;
   logic signed [SUM_W-1:0]   biasedSum;
   logic signed [SUM_W-1:0]   sum_r;
   logic                      sumValid_r;
   logic signed [PROD_W-1:0]  product;
   logic signed [PROD_W-1:0]  scaled;
   logic [`ALCR_SAMPLE_W-1:0] saturated;
   logic                      overHigh;
   logic                      overLow;

   // Linear factor of N x 0.2 dB, unity at ten fractional bits
   always_comb
   begin
      case (chan5GainSteps)
         5'h00: gainFactor = `ALCR_FACTOR_UNITY;
         5'h01: gainFactor = 12'h418;
         5'h02: gainFactor = 12'h430;
         5'h03: gainFactor = 12'h449;
         5'h04: gainFactor = 12'h463;
         5'h05: gainFactor = 12'h47d;
         5'h06: gainFactor = 12'h498;
         5'h07: gainFactor = 12'h4b3;
         5'h08: gainFactor = 12'h4cf;
         5'h09: gainFactor = 12'h4ec;
         5'h0a: gainFactor = 12'h509;
         5'h0b: gainFactor = 12'h527;
         5'h0c: gainFactor = 12'h546;
         5'h0d: gainFactor = 12'h565;
         5'h0e: gainFactor = 12'h586;
         5'h0f: gainFactor = 12'h5a6;
         5'h10: gainFactor = 12'h5c8;
         5'h11: gainFactor = 12'h5eb;
         5'h12: gainFactor = 12'h60e;
         5'h13: gainFactor = 12'h632;
         5'h14: gainFactor = 12'h657;
         5'h15: gainFactor = 12'h67d;
         5'h16: gainFactor = 12'h6a3;
         5'h17: gainFactor = 12'h6cb;
         5'h18: gainFactor = 12'h6f3;
         5'h19: gainFactor = 12'h71d;
         5'h1a: gainFactor = 12'h747;
         5'h1b: gainFactor = 12'h773;
         5'h1c: gainFactor = 12'h79f;
         5'h1d: gainFactor = 12'h7cd;
         5'h1e: gainFactor = 12'h7fb;
         default: gainFactor = 12'h82b;
      endcase
   end

   // Sign-extended sample plus sign-extended offset
   assign biasedSum = SUM_W'(signed'(chan5DataIn))
                    + SUM_W'(signed'(chan5SignedBias));

   // Factor is unsigned, so it is widened with a zero sign bit
   assign product = PROD_W'(sum_r) * PROD_W'(signed'({1'b0, gainFactor}));
   assign scaled  = product >>> `ALCR_FACTOR_FRAC;

   // Clamp to the sample range instead of wrapping
   assign overHigh  = scaled > PROD_W'(signed'(`ALCR_SAT_MAX));
   assign overLow   = scaled < PROD_W'(signed'(`ALCR_SAT_MIN));
   assign saturated = overHigh ? `ALCR_SAT_MAX :
                      overLow  ? `ALCR_SAT_MIN :
                                 scaled[`ALCR_SAMPLE_W-1:0];

   // Offset stage
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sum_r      <= '0;
         sumValid_r <= 1'b0;
      end
      else
      begin
         sum_r      <= chan5Valid ? biasedSum : sum_r;
         sumValid_r <= chan5Valid;
      end
   end

   // Gain stage and output register
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         chan5DataOut      <= {`ALCR_SAMPLE_W{1'b0}};
         chan5DataOutValid <= 1'b0;
      end
      else
      begin
         chan5DataOut      <= sumValid_r ? saturated : chan5DataOut;
         chan5DataOutValid <= sumValid_r;
      end
   end

endmodule

// >>> alcr_lane_control_regs_monitor.sv
// Concurrent checks on the lane control register ports
`include "alcr_consts.svh"

module alcr_lane_control_regs_monitor
   import alcr_pkg::*;
(
   input wire logic                                      sys_clk,
   input wire logic                                      srst,
   input wire logic                                      psel,
   input wire logic                                      penable,
   input wire logic                                      pwrite,
   input wire logic [`ALCR_ADDR_W-1:0]                   paddr,
   input wire logic [31:0]                               pwdata,
   input wire logic                                      laneValid,
   input wire logic [`ALCR_LINES-1:0][`ALCR_SAMPLE_W-1:0] laneDataIn,
   input wire logic [`ALCR_LINES-1:0][`ALCR_SAMPLE_W-1:0] laneDataOut,
   input wire logic [`ALCR_LINES-1:0]                    laneDataOutValid,
   input wire logic                                      chan5Valid,
   input wire logic                                      chan5DataOutValid,
   input wire logic [3:0]                                chanDigitalSleep,
   input wire logic [3:0]                                chanAnalogSleep,
   input wire logic [3:0]                                lineOutputSleep,
   input wire logic [3:0]                                lineDataFlip,
   input wire logic [2:0]                                line3PatternCode,
   input wire logic [`ALCR_GAIN_W-1:0]                   chan5GainSteps,
   input wire logic [`ALCR_BIAS_W-1:0]                   chan5SignedBias
);
   // Write strobes of the power and enable registers
   wire logic wrPower = psel && penable && pwrite && paddr == {`ALCR_IDX_POWER, 2'b00};
   wire logic wrEnab  = psel && penable && pwrite && paddr == {`ALCR_IDX_ENABLES, 2'b00};

   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   AST_DIG_SLEEP: assert property (wrPower |=> chanDigitalSleep == $past(pwdata[15:12]))
      else $error("digital sleep bits differ from written value");
   AST_LINE_SLEEP: assert property (wrPower |=> lineOutputSleep == $past(pwdata[11:8]))
      else $error("line sleep bits differ from written value");
   AST_ANA_SLEEP: assert property (wrPower |=> chanAnalogSleep == $past(pwdata[7:4]))
      else $error("analog sleep bits differ from written value");
   AST_FLIP_LINE1: assert property (laneValid && lineDataFlip[0] && !lineOutputSleep[0]
      |=> laneDataOut[0] == ~$past(laneDataIn[0])) else $error("line 1 word not inverted");
   AST_SLEEP_DROP: assert property (laneValid && lineOutputSleep[3]
      |=> !laneDataOutValid[3] && laneDataOut[3] == '0) else $error("sleeping line 4 sent data");
   AST_PAT_ONES: assert property (laneValid && line3PatternCode == ALCR_PAT_ONES
      && !lineDataFlip[2] && !lineOutputSleep[2] |=> laneDataOut[2] == 14'h3fff)
      else $error("line 3 all-ones word wrong");
   AST_PAT_OFF: assert property (wrEnab && !pwdata[0] |=> line3PatternCode == 3'h0)
      else $error("line 3 pattern active while per-line select off");
   AST_GAIN_OFF: assert property (wrEnab && !pwdata[1] |=> chan5GainSteps == '0)
      else $error("gain steps shown while gain disabled");
   AST_BIAS_OFF: assert property (wrEnab && !pwdata[2] |=> chan5SignedBias == '0)
      else $error("bias shown while offset disabled");
   AST_C5_LATENCY: assert property (chan5Valid |-> ##2 chan5DataOutValid)
      else $error("channel 5 result missing two cycles after input");
endmodule

bind alcr_lane_control_regs alcr_lane_control_regs_monitor mon (.sys_clk, .srst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .laneValid, .laneDataIn, .laneDataOut,
   .laneDataOutValid, .chan5Valid, .chan5DataOutValid, .chanDigitalSleep, .chanAnalogSleep,
   .lineOutputSleep, .lineDataFlip, .line3PatternCode, .chan5GainSteps, .chan5SignedBias);

// >>> alcr_lane_control_regs_tb.sv
// Self-checking bench of the lane control register bank
`include "alcr_consts.svh"

module alcr_lane_control_regs_tb
   import alcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, errSeen;
   logic        laneValid, chan5Valid, chan5DataOutValid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0][13:0] laneDataIn, laneDataOut;
   logic [3:0]  laneDataOutValid, chanDigitalSleep, chanAnalogSleep, lineOutputSleep, lineDataFlip;
   logic [2:0]  line3PatternCode, line4PatternCode;
   logic [13:0] chan5DataIn, chan5DataOut;
   logic [4:0]  chan5GainSteps;
   logic [9:0]  chan5SignedBias;
   int          errTotal, testsRun, cycles;
   logic [11:0] regs [6] = '{12'h05c, 12'h060, 12'h064, 12'h068, 12'h07c, 12'h080};
   logic [13:0] pat [8] = '{14'h0abc, 14'h3f80, 14'h1555, 14'h1234, 14'h3fff, 14'h1555,
                            14'h0000, 14'h0008};

   alcr_lane_control_regs uut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .laneValid, .laneDataIn, .laneDataOut, .laneDataOutValid,
      .chan5Valid, .chan5DataIn, .chan5DataOut, .chan5DataOutValid, .chanDigitalSleep,
      .chanAnalogSleep, .lineOutputSleep, .lineDataFlip, .line3PatternCode, .line4PatternCode,
      .chan5GainSteps, .chan5SignedBias);

   // Clock and hang guard
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errTotal++;
         testDone();
      end
   end

   // ***********************************************
   // Tasks
   // ***********************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Return mid-cycle so that register-driven outputs have settled
      @(negedge sys_clk);
   endtask

   task rdChk(input logic [11:0] a, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
      check(32'(errSeen), 32'(err));
   endtask

   task lane(input logic [13:0] d);
      @(posedge sys_clk);
      laneValid <= 1'b1;
      laneDataIn <= {4{d}};
      @(posedge sys_clk);
      laneValid <= 1'b0;
      @(negedge sys_clk);
   endtask

   task chan5(input logic [13:0] x, input logic [13:0] exp);
      @(posedge sys_clk);
      chan5Valid <= 1'b1;
      chan5DataIn <= x;
      @(posedge sys_clk);
      chan5Valid <= 1'b0;
      @(negedge sys_clk);
      @(negedge sys_clk);
      check(32'(chan5DataOutValid), 32'h1);
      check(32'(chan5DataOut), 32'(exp));
   endtask

   task testDone();
      $display("Checks %0d, mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial
   begin
      {srst, psel, penable, pwrite, paddr, pwdata, laneValid, laneDataIn} = '1;
      {psel, penable, pwrite, paddr, pwdata, laneValid, laneDataIn, chan5Valid, chan5DataIn} = '0;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 0; i < 6; i++) rdChk(regs[i], 32'h0, 1'b0);
      apb(1'b1, 12'h060, 32'hffffa5c3);
      rdChk(12'h060, 32'h0000a5c3, 1'b0);
      check(32'(chanDigitalSleep), 32'ha);
      check(32'(lineOutputSleep), 32'h5);
      check(32'(chanAnalogSleep), 32'hc);
      check(32'(lineDataFlip), 32'h3);
      apb(1'b1, 12'h060, 32'h080f);
      lane(14'h0123);
      check(32'(laneDataOut[0]), 32'h3edc);
      check(32'({laneDataOutValid, laneDataOut[3]}), 32'h1c000);
      apb(1'b1, 12'h060, 32'h0);
      apb(1'b1, 12'h080, 32'h1234);
      apb(1'b1, 12'h05c, 32'h00fc);
      rdChk(12'h05c, 32'h00fc, 1'b0);
      apb(1'b1, 12'h07c, 32'h1);
      for (int c = 0; c < 8; c++)
      begin
         apb(1'b1, 12'h05c, 32'({c[2:0], c[2:0], 2'b00}));
         check(32'({line3PatternCode, line4PatternCode}), 32'({c[2:0], c[2:0]}));
         lane(14'h0abc);
         check(32'(laneDataOut[0]), 32'h0abc);
         check(32'(laneDataOut[3]), 32'(pat[c]));
      end
      apb(1'b1, 12'h07c, 32'h0);
      check(32'(line3PatternCode), 32'h0);
      apb(1'b1, 12'h084, 32'hffff);
      check(32'(errSeen), 32'h1);
      rdChk(12'h061, 32'h0, 1'b1);
      apb(1'b1, 12'h064, 32'hfbff);
      rdChk(12'h064, 32'hfbff, 1'b0);
      apb(1'b1, 12'h068, 32'h03ff);
      rdChk(12'h068, 32'h03ff, 1'b0);
      apb(1'b1, 12'h07c, 32'h6);
      rdChk(12'h07c, 32'h6, 1'b0);
      check(32'({chan5GainSteps, chan5SignedBias}), 32'h7fff);
      chan5(14'd1000, 14'd2039);
      apb(1'b1, 12'h064, 32'h03ff);
      chan5(14'd100, 14'd99);
      apb(1'b1, 12'h064, 32'hf800);
      apb(1'b1, 12'h068, 32'h0);
      chan5(14'h1fff, 14'h1fff);
      apb(1'b1, 12'h07c, 32'h0);
      check(32'({chan5GainSteps, chan5SignedBias}), 32'h0);
      chan5(14'd100, 14'd100);
      testDone();
   end
endmodule
